// *** common/awt_pkg.sv ***
package awt_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_WRAP = 5'h00;
    localparam logic [4:0] OFS_TRIG = 5'h04;
    localparam logic [4:0] OFS_MODE = 5'h08;
    localparam logic [4:0] OFS_START = 5'h0C;
    localparam logic [4:0] OFS_STAT = 5'h10;
    localparam logic [4:0] OFS_RES_HI = 5'h14;
    localparam logic [4:0] OFS_RES_LO = 5'h18;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int WRAP_LSB = 0;
    localparam int TRIG_CLASS_BIT = 7;
    localparam int TRIG_CH_LSB = 0;
    localparam int MODE_EIGHT_BIT = 0;
    localparam int MODE_EXT_EN = 2;
    localparam int MODE_MULTI = 4;
    localparam int MODE_FIRST_LSB = 5;
    localparam int STAT_BUSY = 0;
    localparam int STAT_CH_LSB = 4;
    localparam logic [7:0] RST_WRAP = 8'h07;
    localparam logic [7:0] RST_TRIG = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 2000;
    localparam int CONV_CYCLES =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEQ_LEN = 8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic {ST_IDLE = 1'b0, ST_CONV = 1'b1} awt_state_type;
    typedef enum logic [2:0] {
        REG_NONE, REG_WRAP, REG_TRIG, REG_MODE,
        REG_START, REG_STAT, REG_RES_HI, REG_RES_LO
    } awt_reg_type;
    typedef struct packed {
        logic multi;
        logic [2:0] first;
        logic [2:0] wrap;
    } awt_seq_cfg_type;
    typedef struct packed {
        logic ext_en;
        logic cls;
        logic [2:0] ch;
    } awt_trig_cfg_type;

    function automatic awt_reg_type awt_decode(input logic [4:0] a);
        unique case (a)
            OFS_WRAP: return REG_WRAP;
            OFS_TRIG: return REG_TRIG;
            OFS_MODE: return REG_MODE;
            OFS_START: return REG_START;
            OFS_STAT: return REG_STAT;
            OFS_RES_HI: return REG_RES_HI;
            OFS_RES_LO: return REG_RES_LO;
            default: return REG_NONE;
        endcase
    endfunction

    // Reserved wrap code 000 simply runs on past channel 7 back to 0.
    function automatic logic [2:0] awt_next_chan(input logic [2:0] ch,
                                                 input logic [2:0] wrap);
        if (wrap != 3'h0 && ch == wrap) begin
            return 3'h0;
        end
        return ch + 3'h1;
    endfunction

endpackage

// *** rtl/awt_trig_sel.sv ***
module awt_trig_sel import awt_pkg::*; #(
    parameter bit HAS_DED = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire awt_trig_cfg_type cfg,
    input wire logic [7:0] analog_dig_in,
    input wire logic [3:0] dedicated_trigger_inputs,
    output logic trig_level,
    output logic trig_event
);

    logic last_ff;
    logic nxt_last;

    // ----------------------------------------------------------------
    // Source multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        if (cfg.cls && HAS_DED) begin
            // Codes 1XX select nothing, so a reserved code stays quiet.
            trig_level = !cfg.ch[2] &&
                dedicated_trigger_inputs[cfg.ch[1:0]]; // RL6
        end else begin
            trig_level = analog_dig_in[cfg.ch]; // RL5 RL7
        end
    end

    // ----------------------------------------------------------------
    // Rising edge, gated by the enable
    // ----------------------------------------------------------------
    always_comb begin
        nxt_last = trig_level;
        trig_event = cfg.ext_en && trig_level && !last_ff; // RL9
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= nxt_last;
        end
    end

endmodule

// *** rtl/awt_seq.sv ***
module awt_seq import awt_pkg::*; #(
    parameter int CONV_N = CONV_CYCLES,
    parameter int LEN = SEQ_LEN
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire awt_seq_cfg_type cfg,
    input wire logic start,
    input wire logic abort,
    output logic busy,
    output logic [2:0] chan,
    output logic conv_done,
    output logic seq_done
);

    localparam int CW = $clog2(CONV_N + 1);
    localparam int LW = $clog2(LEN + 1);

    awt_state_type state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [LW-1:0] num_ff, nxt_num;
    logic [2:0] chan_ff, nxt_chan;

    // ----------------------------------------------------------------
    // Sequence control
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_num = num_ff;
        nxt_chan = chan_ff;
        conv_done = 1'b0;
        seq_done = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (start && !abort) begin
                    nxt_state = ST_CONV;
                    nxt_cnt = '0;
                    nxt_num = '0;
                    nxt_chan = cfg.first;
                end
            end
            ST_CONV: begin
                if (abort) begin
                    nxt_state = ST_IDLE; // RL1
                end else if (cnt_ff == CW'(CONV_N - 1)) begin
                    conv_done = 1'b1;
                    nxt_cnt = '0;
                    nxt_num = num_ff + LW'(1);
                    if (cfg.multi) begin
                        nxt_chan = awt_next_chan(chan_ff, cfg.wrap); // RL3
                    end
                    if (num_ff == LW'(LEN - 1)) begin
                        seq_done = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                end else begin
                    nxt_cnt = cnt_ff + CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            num_ff <= '0;
            chan_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            num_ff <= nxt_num;
            chan_ff <= nxt_chan;
        end
    end

    assign busy = (state_ff == ST_CONV);
    assign chan = chan_ff;

endmodule

// *** rtl/awt_top.sv ***
// Overview of operation
// RL1: Writing wrap or trigger-source control aborts the sequence, never starts one.
// RL2: Wrap control bits 2..0 hold the wrap channel.
// RL3: Multi-channel: after the wrap channel (1..7) the next channel is 0.
// RL4: Trigger-source bit 7 picks analog channel (0) or dedicated input (1).
// RL5: With class 0, trigger field n selects analog channel n.
// RL6: With class 1, codes 0..3 pick dedicated inputs 0..3; 1XX reserved.
// RL7: Without dedicated inputs, class bit is stored only; analog source stays.
// RL8: Channel 7 result is right justified for 10-bit and 8-bit modes.
// RL9: The selected source triggers only while the enable bit is set.
// RL10: Reserved wrap and trigger codes are stored as written.
module awt_top import awt_pkg::*; #(
    parameter bit HAS_DED = 1'b1,
    parameter int CONV_N = CONV_CYCLES,
    parameter int LEN = SEQ_LEN
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] analog_dig_in,
    input wire logic [3:0] dedicated_trigger_inputs,
    input wire logic [9:0] conv_result,
    output logic [2:0] conv_chan,
    output logic conv_active,
    output logic seq_complete
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic aw_have_ff, nxt_aw_have;
    logic w_have_ff, nxt_w_have;
    logic [4:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic wlane_ff, nxt_wlane;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [2:0] wrap_ff, nxt_wrap;
    logic trig_cls_ff, nxt_trig_cls;
    logic [2:0] trig_ch_ff, nxt_trig_ch;
    logic [7:0] mode_ff, nxt_mode;
    logic [9:0] res7_ff, nxt_res7;
    logic done_ff, nxt_done;
    logic wr_fire;
    awt_reg_type wr_sel;
    awt_reg_type rd_sel;
    logic ctl_write;
    logic sw_start;
    logic eight_bit;
    logic [7:0] res_hi_view;
    logic [7:0] res_lo_view;
    awt_seq_cfg_type seq_cfg;
    awt_trig_cfg_type trig_cfg;
    logic trig_level;
    logic trig_event;
    logic busy;
    logic [2:0] chan;
    logic conv_done;
    logic seq_done;

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data are parked separately so either may come first;
    // the register update happens one cycle after both are held.
    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready = !w_have_ff && !bvalid_ff;
    assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_sel = awt_decode(awaddr_ff);
    assign ctl_write = wr_fire && (wr_sel == REG_WRAP || wr_sel == REG_TRIG);
    assign sw_start = wr_fire && wr_sel == REG_START && wlane_ff;

    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_w_have = w_have_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wlane = wlane_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_have = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_have = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wlane = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            nxt_aw_have = 1'b0;
            nxt_w_have = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= 5'h00;
            wdata_ff <= 32'h0000_0000;
            wlane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff <= nxt_w_have;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wlane_ff <= nxt_wlane;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ----------------------------------------------------------------
    // Control registers and channel 7 result
    // ----------------------------------------------------------------
    always_comb begin
        nxt_wrap = wrap_ff;
        nxt_trig_cls = trig_cls_ff;
        nxt_trig_ch = trig_ch_ff;
        nxt_mode = mode_ff;
        nxt_res7 = res7_ff;
        nxt_done = seq_done;
        if (wr_fire && wlane_ff) begin
            unique case (wr_sel)
                REG_WRAP: nxt_wrap = wdata_ff[WRAP_LSB +: 3]; // RL2 RL10
                REG_TRIG: begin
                    nxt_trig_cls = wdata_ff[TRIG_CLASS_BIT]; // RL4 RL7
                    nxt_trig_ch = wdata_ff[TRIG_CH_LSB +: 3]; // RL5 RL10
                end
                REG_MODE: nxt_mode = wdata_ff[7:0];
                default: nxt_mode = mode_ff;
            endcase
        end
        if (conv_done && chan == 3'h7) begin
            nxt_res7 = conv_result;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_ff <= RST_WRAP[2:0];
            trig_cls_ff <= RST_TRIG[TRIG_CLASS_BIT];
            trig_ch_ff <= RST_TRIG[2:0];
            mode_ff <= RST_MODE;
            res7_ff <= 10'h000;
            done_ff <= 1'b0;
        end else begin
            wrap_ff <= nxt_wrap;
            trig_cls_ff <= nxt_trig_cls;
            trig_ch_ff <= nxt_trig_ch;
            mode_ff <= nxt_mode;
            res7_ff <= nxt_res7;
            done_ff <= nxt_done;
        end
    end

    // The 8-bit view keeps the top eight converter bits, so switching
    // resolution reinterprets the stored sample rather than losing it.
    assign eight_bit = mode_ff[MODE_EIGHT_BIT];
    assign res_hi_view = eight_bit ? 8'h00 : {6'h00, res7_ff[9:8]}; // RL8
    assign res_lo_view = eight_bit ? res7_ff[9:2] : res7_ff[7:0]; // RL8

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !rvalid_ff;
    assign rd_sel = awt_decode(s_axi_araddr);

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            unique case (rd_sel)
                REG_WRAP: nxt_rdata[2:0] = wrap_ff;
                REG_TRIG: begin
                    nxt_rdata[TRIG_CLASS_BIT] = trig_cls_ff;
                    nxt_rdata[2:0] = trig_ch_ff;
                end
                REG_MODE: nxt_rdata[7:0] = mode_ff;
                REG_STAT: begin
                    nxt_rdata[STAT_BUSY] = busy;
                    nxt_rdata[STAT_CH_LSB +: 3] = chan;
                end
                REG_RES_HI: nxt_rdata[7:0] = res_hi_view;
                REG_RES_LO: nxt_rdata[7:0] = res_lo_view;
                REG_START: nxt_rdata = 32'h0000_0000;
                REG_NONE: nxt_rresp = RESP_SLVERR;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ----------------------------------------------------------------
    // Trigger selection and sequencer
    // ----------------------------------------------------------------
    assign trig_cfg = '{ext_en: mode_ff[MODE_EXT_EN], cls: trig_cls_ff,
                        ch: trig_ch_ff};
    assign seq_cfg = '{multi: mode_ff[MODE_MULTI],
                       first: mode_ff[MODE_FIRST_LSB +: 3], wrap: wrap_ff};

    awt_trig_sel #(.HAS_DED(HAS_DED)) u_trig (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(trig_cfg),
        .analog_dig_in(analog_dig_in),
        .dedicated_trigger_inputs(dedicated_trigger_inputs),
        .trig_level(trig_level),
        .trig_event(trig_event)
    );

    // A control write in the same cycle as a start wins: it aborts.
    awt_seq #(.CONV_N(CONV_N), .LEN(LEN)) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(seq_cfg),
        .start(sw_start || trig_event),
        .abort(ctl_write), // RL1
        .busy(busy),
        .chan(chan),
        .conv_done(conv_done),
        .seq_done(seq_done)
    );

    assign conv_chan = chan;
    assign conv_active = busy;
    assign seq_complete = done_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ctl_write_abort: assert property ( // RL1
        ctl_write |=> !busy ##1 (!busy || $past(sw_start || trig_event)))
        else $error("control write did not abort the sequence");

    a_wrap_field_store: assert property ( // RL2
        wr_fire && wlane_ff && wr_sel == REG_WRAP
        |=> wrap_ff == $past(wdata_ff[2:0]))
        else $error("wrap field not stored");

    a_wrap_to_zero: assert property ( // RL3
        conv_done && !seq_done && seq_cfg.multi && wrap_ff != 3'h0
        && chan == wrap_ff && !ctl_write |=> chan == 3'h0)
        else $error("sequence did not wrap to channel zero");

    a_class_bit_store: assert property ( // RL4
        wr_fire && wlane_ff && wr_sel == REG_TRIG
        |=> trig_cls_ff == $past(wdata_ff[7])
            && trig_ch_ff == $past(wdata_ff[2:0]))
        else $error("trigger source control not stored");

    a_analog_source: assert property ( // RL5
        (!trig_cls_ff || !HAS_DED) |-> trig_level == analog_dig_in[trig_ch_ff])
        else $error("analog trigger source wrong");

    a_dedicated_source: assert property ( // RL6
        trig_cls_ff && HAS_DED |-> trig_level ==
        (!trig_ch_ff[2] && dedicated_trigger_inputs[trig_ch_ff[1:0]]))
        else $error("dedicated trigger source wrong");

    a_trig_gated: assert property ( // RL9
        !mode_ff[MODE_EXT_EN] && !busy && !sw_start |=> !busy)
        else $error("sequence started without enabled trigger");

    a_result_format: assert property ( // RL8
        conv_done && chan == 3'h7 && !(wr_fire && wr_sel == REG_MODE)
        |=> res_lo_view == (eight_bit ? $past(conv_result[9:2])
                                      : $past(conv_result[7:0]))
            && res_hi_view == (eight_bit ? 8'h00
                                         : {6'h00, $past(conv_result[9:8])}))
        else $error("channel 7 result layout wrong");

    a_seq_length: assert property (
        seq_done |=> seq_complete && !busy)
        else $error("sequence end not reported");

    c_abort_busy: cover property (busy && ctl_write);
    c_wrap_seen: cover property (conv_done && chan == wrap_ff
                                 && seq_cfg.multi ##1 chan == 3'h0);
    c_ext_start: cover property (trig_event && !busy ##1 busy);
    c_seq_done: cover property (seq_done);

endmodule

// *** tb/adc_wrap_and_trigger_select_test.sv ***
module adc_wrap_and_trigger_select_test import awt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, last_bresp;
    logic [31:0] rdata;
    logic [7:0] analog_in = 8'h00;
    logic [3:0] ded_in = 4'h0;
    logic [9:0] conv_result = 10'h2B5;
    logic [2:0] conv_chan, chan_d;
    logic conv_active, seq_complete;
    logic act_d = 1'b0;
    logic [2:0] chq[$];
    int bad_count = 0;
    int checked = 0;

    always #25 aclk = ~aclk;

    // ------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------
    // Short counts keep every sequence to twelve cycles.
    awt_top #(.HAS_DED(1'b1), .CONV_N(3), .LEN(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .analog_dig_in(analog_in),
        .dedicated_trigger_inputs(ded_in),
        .conv_result(conv_result), .conv_chan(conv_chan),
        .conv_active(conv_active), .seq_complete(seq_complete));

    // Each new channel of a running sequence is logged once.
    always @(posedge aclk) begin
        if (conv_active && (!act_d || conv_chan != chan_d))
            chq.push_back(conv_chan);
        act_d <= conv_active;
        chan_d <= conv_chan;
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic timeout;
        bad_count++;
        $display("timeout at %0t", $time);
        wrap_up();
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // Both wr and rchk open on a fresh edge, so bready and rready are never
    // assigned twice in one time step by back-to-back calls.
    task automatic wr(input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        last_bresp = bresp;
        if (n == 50) timeout();
    endtask

    task automatic rchk(input logic [4:0] a, input logic [7:0] e,
                        input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) timeout();
        chk(rdata, {24'h00_0000, e});
        chk({30'h0000_0000, rresp}, {30'h0000_0000, er});
    endtask

    task automatic waitseq;
        int n;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (seq_complete) break;
        end
        if (n == 200) timeout();
    endtask

    // Sources are parked low first so that only the raise is an edge;
    // the closing wrap write aborts whatever the trigger started.
    task automatic trig(input logic [7:0] t, input logic [7:0] an,
                        input logic [3:0] dd, input logic e);
        int n;
        analog_in <= 8'h00;
        ded_in <= 4'h0;
        wr(OFS_TRIG, t, 4'h1);
        repeat (3) @(posedge aclk);
        analog_in <= an;
        ded_in <= dd;
        for (n = 0; n < 8 && !conv_active; n++) @(posedge aclk);
        chk(conv_active, e);
        wr(OFS_WRAP, 8'h07, 4'h1);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0] ch;
        int i;
        int k;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(OFS_WRAP, RST_WRAP, RESP_OKAY);
        rchk(OFS_TRIG, RST_TRIG, RESP_OKAY);
        rchk(OFS_MODE, RST_MODE, RESP_OKAY);
        rchk(5'h1C, 8'h00, RESP_SLVERR);
        wr(5'h1C, 8'h5A, 4'h1);
        chk(last_bresp, RESP_SLVERR);
        wr(OFS_WRAP, 8'hF8, 4'h1);
        rchk(OFS_WRAP, 8'h00, RESP_OKAY);
        wr(OFS_TRIG, 8'hFE, 4'h1);
        rchk(OFS_TRIG, 8'h86, RESP_OKAY);
        $display("register test done");
        for (k = 1; k < 8; k += 3) begin
            chq.delete();
            wr(OFS_WRAP, {5'h00, k[2:0]}, 4'h1);
            wr(OFS_MODE, {k[2:0] - 3'h1, 5'h10}, 4'h1);
            wr(OFS_START, 8'h01, 4'h1);
            waitseq();
            chk(chq.size(), 4);
            ch = k[2:0] - 3'h1;
            for (i = 0; i < 4; i++) begin
                chk(chq[i], ch);
                ch = (ch == k[2:0]) ? 3'h0 : ch + 3'h1;
            end
        end
        $display("wrap test done");
        for (k = 0; k < 2; k++) begin
            wr(OFS_START, 8'h01, 4'h1);
            repeat (2) @(posedge aclk);
            chk(conv_active, 1'b1);
            wr(k ? OFS_TRIG : OFS_WRAP, k ? 8'h86 : 8'h07, {3'h0, !k[0]});
            chk(conv_active, 1'b0);
            repeat (10) @(posedge aclk);
            chk(conv_active, 1'b0);
            rchk(OFS_STAT, 8'h70, RESP_OKAY);
        end
        $display("abort test done");
        wr(OFS_MODE, 8'hE0, 4'h1);
        wr(OFS_START, 8'h01, 4'h1);
        waitseq();
        rchk(OFS_RES_HI, 8'h02, RESP_OKAY);
        rchk(OFS_RES_LO, 8'hB5, RESP_OKAY);
        wr(OFS_MODE, 8'hE1, 4'h1);
        rchk(OFS_RES_HI, 8'h00, RESP_OKAY);
        rchk(OFS_RES_LO, 8'hAD, RESP_OKAY);
        $display("result test done");
        wr(OFS_MODE, 8'h04, 4'h1);
        for (k = 0; k < 8; k++) begin
            trig({5'h00, k[2:0]}, 8'h01 << k, 4'h0, 1'b1);
            trig({5'h00, k[2:0]}, ~(8'h01 << k), 4'hF, 1'b0);
        end
        for (k = 0; k < 4; k++) begin
            trig({5'h10, k[2:0]}, 8'h00, 4'h1 << k, 1'b1);
            trig({5'h10, k[2:0]}, 8'hFF, ~(4'h1 << k), 1'b0);
        end
        for (k = 4; k < 8; k++)
            trig({5'h10, k[2:0]}, 8'hFF, 4'hF, 1'b0);
        wr(OFS_MODE, 8'h00, 4'h1);
        trig(8'h00, 8'h01, 4'h0, 1'b0);
        trig(8'h80, 8'h00, 4'h1, 1'b0);
        $display("trigger test done");
        wrap_up();
    end
endmodule
